//--- rgbcfg_top.sv
// Functional notes
// - Rise from low nibble, fall from high
// - Duration field times 128 ms, scaled; zero 2ms
// - One scaling setting for both ramps
// - Scaling codes: normal, 2x, 4x slower, 8x faster
// - Three current codes, one per sink
// - Current is code plus one, saturating at BF
// - Two low bits time-multiplexed over 0.5mA base
// - Select bit0 low: bus lines decide shutdown
// - Select 01: always powered on
// - Select 11: software sleep
// - SDA changes only while SCL low
// - Start and stop from SDA edges, SCL high
// - Eight bits MSB first, then acknowledge
// - Acknowledge each received byte on writes
// - Respond to address 60h write, 61h read
// - Write: address, index nibble, data, stop
// - Repeated index/data pairs before stop
// - Read: address, index, returned byte, nack
`timescale 1ns/1ps
`default_nettype none
module rgbcfg_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Serial bus pins (SDA open drain)
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Ramp durations in ms
    output logic [12:0] rise_ramp_duration,
    output logic [12:0] fall_ramp_duration,
    // Sink drive levels in 0.5 mA units
    output logic [5:0] first_sink_level,
    output logic [5:0] second_sink_level,
    output logic [5:0] third_sink_level,
    // Power state
    output logic device_shutdown
);
    import rgbcfg_pkg::*;
    // ------------------------------------------------------------------------
    // State of the block
    // ------------------------------------------------------------------------
    typedef struct packed {
        rgbcfg_state_t st;        // Serial engine state
        logic [2:0] bcnt;         // Bit counter within a byte
        logic [7:0] sh;           // Shift register
        logic rd;                 // Read direction latched from address
        logic [3:0] idx;          // Register index
        logic [7:0] gen_ctrl;     // general_control
        logic [7:0] ramp;         // ramp_time_setting
        logic [2:0][7:0] cur;     // Channel current codes
        logic [1:0] sdsel;        // shutdown_select, implemented bits only
        logic scl1, scl2, scl3;   // SCL synchroniser and edge history
        logic sda1, sda2, sda3;   // SDA synchroniser and edge history
        logic oe;                 // SDA pull-down
        logic [6:0] div;          // Oscillator divider
        logic [1:0] phase;        // Interpolator phase
        logic [12:0] rise;        // Rise duration output
        logic [12:0] fall;        // Fall duration output
        logic [2:0][5:0] lvl;     // Sink levels
        logic shdn;               // Shutdown output
    } rgbcfg_q_t;
    rgbcfg_q_t q_r;
    rgbcfg_q_t q_nxt;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rx_byte;
    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    // scaled ramp duration
    function automatic logic [12:0] ramp_ms(input logic [3:0] f, input logic [1:0] sc);
        logic [12:0] base;
        base = 13'(f * RAMP_UNIT_MS);
        if (f == 4'h0) begin
            ramp_ms = RAMP_ZERO_MS;
        end else begin
            unique case (sc)
                SCALE_NORMAL: ramp_ms = base;
                SCALE_SLOW2: ramp_ms = base << 1;
                SCALE_SLOW4: ramp_ms = base << 2;
                SCALE_FAST8: ramp_ms = base >> FAST_SHIFT;
            endcase
        end
    endfunction
    // Count of 0.125 mA steps for a current code
    function automatic logic [7:0] sink_steps(input logic [7:0] code);
        sink_steps = (code > CUR_MAX_CODE) ? CUR_FULL_STEPS : 8'(code + 8'h01);
    endfunction
    // Read-back value of an index; unmapped indices read zero
    function automatic logic [7:0] rd_reg(input rgbcfg_q_t s, input logic [3:0] i);
        unique case (i)
            IDX_GENERAL_CONTROL: rd_reg = s.gen_ctrl;
            IDX_RAMP_TIME: rd_reg = s.ramp;
            IDX_CHANNEL1_CURRENT: rd_reg = s.cur[0];
            IDX_CHANNEL2_CURRENT: rd_reg = s.cur[1];
            IDX_CHANNEL3_CURRENT: rd_reg = s.cur[2];
            IDX_SHUTDOWN_SELECT: rd_reg = {6'h00, s.sdsel};
            default: rd_reg = 8'h00;
        endcase
    endfunction
    // ------------------------------------------------------------------------
    // Bus conditions seen through the synchronisers
    // ------------------------------------------------------------------------
    assign scl_rise = q_r.scl2 & ~q_r.scl3;
    assign scl_fall = ~q_r.scl2 & q_r.scl3;
    assign bus_start = q_r.scl2 & q_r.scl3 & ~q_r.sda2 & q_r.sda3;
    assign bus_stop = q_r.scl2 & q_r.scl3 & q_r.sda2 & ~q_r.sda3;
    assign rx_byte = {q_r.sh[6:0], q_r.sda2};
    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        logic [7:0] steps;
        logic [7:0] tx;
        steps = 8'h00;
        tx = rd_reg(q_r, q_r.idx);
        q_nxt = q_r;
        // Two-flop synchronisers, third stage for edge finding
        q_nxt.scl1 = scl_in;
        q_nxt.scl2 = q_r.scl1;
        q_nxt.scl3 = q_r.scl2;
        q_nxt.sda1 = sda_in;
        q_nxt.sda2 = q_r.sda1;
        q_nxt.sda3 = q_r.sda2;
        if (bus_start) begin
            // Start or repeated start aborts anything in flight
            q_nxt.st = ST_ADDR;
            q_nxt.bcnt = 3'h0;
            q_nxt.oe = 1'b0;
        end else if (bus_stop) begin
            // Stop returns to idle and frees SDA
            q_nxt.st = ST_IDLE;
            q_nxt.oe = 1'b0;
        end else begin
            // SDA drive moves only on SCL falling edges
            unique case (q_r.st)
                ST_IDLE: begin
                    q_nxt.oe = 1'b0;
                end
                ST_ADDR, ST_INDEX, ST_WDATA: begin
                    if (scl_rise) begin
                        q_nxt.sh = rx_byte;
                        q_nxt.bcnt = 3'(q_r.bcnt + 3'h1);
                        if (q_r.bcnt == 3'h7) begin
                            unique case (q_r.st)
                                ST_ADDR: begin
                                    // match address, else stay off bus
                                    if (rx_byte[7:1] == RGBCFG_TGT_ADDR) begin
                                        q_nxt.rd = rx_byte[0];
                                        q_nxt.st = ST_ACK_A;
                                    end else begin
                                        q_nxt.st = ST_IDLE;
                                    end
                                end
                                ST_INDEX: begin
                                    q_nxt.idx = rx_byte[3:0];
                                    q_nxt.st = ST_ACK_I;
                                end
                                default: begin
                                    // store into the index just received
                                    q_nxt.st = ST_ACK_D;
                                    unique case (q_r.idx)
                                        IDX_GENERAL_CONTROL: q_nxt.gen_ctrl = rx_byte;
                                        IDX_RAMP_TIME: q_nxt.ramp = rx_byte;
                                        IDX_CHANNEL1_CURRENT: q_nxt.cur[0] = rx_byte;
                                        IDX_CHANNEL2_CURRENT: q_nxt.cur[1] = rx_byte;
                                        IDX_CHANNEL3_CURRENT: q_nxt.cur[2] = rx_byte;
                                        IDX_SHUTDOWN_SELECT: q_nxt.sdsel = rx_byte[1:0];
                                        default: q_nxt.sdsel = q_r.sdsel;
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                ST_ACK_A, ST_ACK_I, ST_ACK_D: begin
                    // pull low for one SCL period
                    if (scl_fall) begin
                        if (!q_r.oe) begin
                            q_nxt.oe = 1'b1;
                        end else if (q_r.st == ST_ACK_I && q_r.rd) begin
                            // first data bit of the returned byte
                            q_nxt.st = ST_TX;
                            q_nxt.sh = tx;
                            q_nxt.bcnt = 3'h0;
                            q_nxt.oe = ~tx[7];
                        end else begin
                            q_nxt.oe = 1'b0;
                            q_nxt.bcnt = 3'h0;
                            q_nxt.st = (q_r.st == ST_ACK_I) ? ST_WDATA : ST_INDEX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        q_nxt.sh = {q_r.sh[6:0], 1'b0};
                        q_nxt.oe = ~q_r.sh[6];
                    end else if (scl_rise) begin
                        q_nxt.bcnt = 3'(q_r.bcnt + 3'h1);
                        if (q_r.bcnt == 3'h7) begin
                            q_nxt.st = ST_TX_END;
                        end
                    end
                end
                ST_TX_END: begin
                    // release SDA for the host's answer
                    if (scl_fall) begin
                        q_nxt.oe = 1'b0;
                        q_nxt.st = ST_HOST_ACK;
                    end
                end
                ST_HOST_ACK: begin
                    // Answer bit sampled; wait for stop
                    if (scl_rise) begin
                        q_nxt.st = ST_IDLE;
                    end
                end
            endcase
        end
        // Oscillator tick and interpolator phase
        if (q_r.div == OSC_DIV_LAST) begin
            q_nxt.div = 7'h00;
            q_nxt.phase = 2'(q_r.phase + 2'h1);
        end else begin
            q_nxt.div = 7'(q_r.div + 7'h01);
        end
        q_nxt.rise = ramp_ms(q_r.ramp[RISE_FIELD_LSB +: 4], q_r.gen_ctrl[SCALE_FIELD_LSB +: 2]);
        q_nxt.fall = ramp_ms(q_r.ramp[FALL_FIELD_LSB +: 4], q_r.gen_ctrl[SCALE_FIELD_LSB +: 2]);
        // Shutdown selection
        if (q_r.sdsel == SHDN_SOFTWARE) begin
            q_nxt.shdn = 1'b1;
        end else if (q_r.sdsel == SHDN_ALWAYS_ON) begin
            q_nxt.shdn = 1'b0;
        end else begin
            unique case (q_r.gen_ctrl[BUS_SHDN_FIELD_LSB +: 2])
                BUS_SHDN_SCL_LOW: q_nxt.shdn = ~q_r.scl2;
                BUS_SHDN_SDA_LOW: q_nxt.shdn = ~q_r.sda2;
                BUS_SHDN_BOTH_LOW: q_nxt.shdn = ~q_r.scl2 & ~q_r.sda2;
                default: q_nxt.shdn = 1'b0;
            endcase
        end
        // Sink levels per channel
        for (int k = 0; k < 3; k++) begin
            steps = sink_steps(q_r.cur[k]);
            // dither two low bits over four phases
            q_nxt.lvl[k] = q_r.shdn ? 6'h00 : 6'(steps[7:2] + {5'h00, (q_r.phase < steps[1:0])});
        end
    end
    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            q_r <= '0;
            q_r.st <= ST_IDLE;
            q_r.gen_ctrl <= RESET_BYTE;
            q_r.ramp <= RESET_BYTE;
            q_r.cur <= {3{RESET_BYTE}};
            q_r.sdsel <= RESET_SHDN_SEL;
            q_r.scl1 <= 1'b1;
            q_r.scl2 <= 1'b1;
            q_r.scl3 <= 1'b1;
            q_r.sda1 <= 1'b1;
            q_r.sda2 <= 1'b1;
            q_r.sda3 <= 1'b1;
            q_r.rise <= RAMP_ZERO_MS;
            q_r.fall <= RAMP_ZERO_MS;
        end else begin
            q_r <= q_nxt;
        end
    end
    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign sda_out = 1'b0;
    assign sda_oe = q_r.oe;
    assign rise_ramp_duration = q_r.rise;
    assign fall_ramp_duration = q_r.fall;
    assign first_sink_level = q_r.lvl[0];
    assign second_sink_level = q_r.lvl[1];
    assign third_sink_level = q_r.lvl[2];
    assign device_shutdown = q_r.shdn;
    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence ack_begin;
        (q_r.st == ST_ACK_A || q_r.st == ST_ACK_I || q_r.st == ST_ACK_D) && scl_fall && !q_r.oe;
    endsequence
    sequence next_low;
        ##[0:1000] scl_fall;
    endsequence
    a_ack_hold: assert property (ack_begin |=> sda_oe throughout next_low)
        else $error("acknowledge not held for a full SCL period");
    a_sda_move: assert property ((sda_oe != $past(sda_oe)) && !$past(bus_start) && !$past(bus_stop)
        |-> $past(scl_fall) || $past(q_r.st) == ST_IDLE)
        else $error("SDA drive changed outside SCL low");
    a_rise_zero: assert property (q_r.ramp[3:0] == 4'h0 |=> rise_ramp_duration == 13'h0002)
        else $error("zero rise field not 2 ms");
    a_fall_fast: assert property (q_r.gen_ctrl[6:5] == 2'h3 && q_r.ramp[7:4] != 4'h0
        |=> fall_ramp_duration == 13'($past(q_r.ramp[7:4]) * 16))
        else $error("fast fall duration wrong");
    a_rise_slow: assert property (q_r.gen_ctrl[6:5] == 2'h2 && q_r.ramp[3:0] != 4'h0
        |=> rise_ramp_duration == 13'($past(q_r.ramp[3:0]) * 512))
        else $error("4x slower rise duration wrong");
    a_cur_sat: assert property (q_r.cur[0] > 8'hBF && !q_r.shdn |=> first_sink_level == 6'h30)
        else $error("saturated code not full scale");
    a_tdm_base: assert property (q_r.cur[1][1:0] == 2'h3 && q_r.cur[1] <= 8'hBF && !q_r.shdn
        |=> second_sink_level == 6'($past(q_r.cur[1][7:2]) + 6'h01))
        else $error("code with low bits 3 not on next unit");
    a_stay_on: assert property (q_r.sdsel == 2'h1 |=> !device_shutdown)
        else $error("always-on selection shut down");
    a_sw_sleep: assert property (q_r.sdsel == 2'h3 |=> device_shutdown ##1 third_sink_level == 6'h00)
        else $error("software sleep not entered");
    a_resv_zero: assert property (q_r.st == ST_TX && q_r.idx == 4'hA |-> q_r.bcnt > 3'h5 || sda_oe)
        else $error("reserved shutdown-select bit read as one");
endmodule
`default_nettype wire

//--- rgbcfg_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants of the RGB sink configuration port
// ----------------------------------------------------------------------------
package rgbcfg_pkg;
    // Seven-bit target address; direction bit follows it on the wire
    localparam logic [6:0] RGBCFG_TGT_ADDR = 7'h30;
    // Register indices carried in the low nibble of the index byte
    localparam logic [3:0] IDX_GENERAL_CONTROL = 4'h0;
    localparam logic [3:0] IDX_RAMP_TIME = 4'h5;
    localparam logic [3:0] IDX_CHANNEL1_CURRENT = 4'h6;
    localparam logic [3:0] IDX_CHANNEL2_CURRENT = 4'h7;
    localparam logic [3:0] IDX_CHANNEL3_CURRENT = 4'h8;
    localparam logic [3:0] IDX_SHUTDOWN_SELECT = 4'hA;
    // Field positions
    localparam int RISE_FIELD_LSB = 0;
    localparam int FALL_FIELD_LSB = 4;
    localparam int SCALE_FIELD_LSB = 5;
    localparam int BUS_SHDN_FIELD_LSB = 3;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_SHDN_SEL = 2'h0;
    // Ramp scaling codes
    localparam logic [1:0] SCALE_NORMAL = 2'h0;
    localparam logic [1:0] SCALE_SLOW2 = 2'h1;
    localparam logic [1:0] SCALE_SLOW4 = 2'h2;
    localparam logic [1:0] SCALE_FAST8 = 2'h3;
    // Ramp step and the fixed time of a zero field, in ms
    localparam logic [12:0] RAMP_UNIT_MS = 13'h0080;
    localparam logic [12:0] RAMP_ZERO_MS = 13'h0002;
    localparam int FAST_SHIFT = 3;
    // Current codes: highest linear code and saturated count of 0.125 mA steps
    localparam logic [7:0] CUR_MAX_CODE = 8'hBF;
    localparam logic [7:0] CUR_FULL_STEPS = 8'hC0;
    // Shutdown selection codes
    localparam logic [1:0] SHDN_ALWAYS_ON = 2'h1;
    localparam logic [1:0] SHDN_SOFTWARE = 2'h3;
    // Bus-line shutdown sub-modes
    localparam logic [1:0] BUS_SHDN_SCL_LOW = 2'h1;
    localparam logic [1:0] BUS_SHDN_SDA_LOW = 2'h2;
    localparam logic [1:0] BUS_SHDN_BOTH_LOW = 2'h3;
    // Interpolator tick: internal oscillator rate derived from mclk
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int OSC_FREQ_HZ = 1_000_000;
    localparam int OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam logic [6:0] OSC_DIV_LAST = 7'(OSC_DIV - 1);
    // Serial engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_A, ST_INDEX, ST_ACK_I, ST_WDATA, ST_ACK_D, ST_TX, ST_TX_END, ST_HOST_ACK
    } rgbcfg_state_t;
endpackage
`default_nettype wire

//--- rgbcfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus controller model on the far side
// ----------------------------------------
module rgbcfg_host_model (
    // Clock
    input wire logic mclk,
    // Resolved data line
    input wire logic sda_line,
    // Driven lines, high means released
    output var logic scl,
    output var logic sda
);
    // Both lines released at power-up
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Wait a number of clocks
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic bit_io(input logic b, output logic got);
        tk(4);
        sda <= b;
        tk(4);
        scl <= 1'b1;
        tk(8);
        got = sda_line;
        scl <= 1'b0;
    endtask
    // Start: SDA falls while SCL high, SCL then left low
    task automatic start_cond();
        tk(4);
        sda <= 1'b1;
        tk(4);
        scl <= 1'b1;
        tk(8);
        sda <= 1'b0;
        tk(8);
        scl <= 1'b0;
    endtask
    // Stop: SDA rises while SCL high
    task automatic stop_cond();
        tk(4);
        sda <= 1'b0;
        tk(4);
        scl <= 1'b1;
        tk(8);
        sda <= 1'b1;
        tk(8);
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], g);
            q[i] = g;
        end
        bit_io(1'b1, g);
        ack = ~g;
    endtask
    // Park the bus with SCL low, SDA released
    task automatic park();
        tk(1);
        scl <= 1'b0;
    endtask
    // Pull SDA low only while SCL is parked low
    task automatic sda_low();
        tk(1);
        sda <= 1'b0;
    endtask
    // Release SDA first, then SCL, leaving the bus idle
    task automatic unpark();
        tk(1);
        sda <= 1'b1;
        tk(4);
        scl <= 1'b1;
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench of the configuration port
// ----------------------------------------
module testbench;
    import rgbcfg_pkg::*;
    // Clock, reset and bus lines
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic scl, sda_h, sda_out, sda_oe, sda_line, dev_shdn, ack;
    // Design outputs and bench bytes
    logic [12:0] rise_d, fall_d;
    logic [5:0] lv1, lv2, lv3;
    logic [7:0] rd, d;
    // Counters, seed and behavioural register file
    int error_cnt = 0;
    int comparisons = 0;
    int seed = 32'hDEAA;
    logic [7:0] mdl [16];
    logic [3:0] regs [6] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA};
    logic [7:0] edge_codes [4] = '{8'h00, 8'hBF, 8'hC0, 8'hFF};
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // Wired-and data line
    assign sda_line = sda_h & ~(sda_oe & ~sda_out);
    rgbcfg_top i_dut (
        .mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .rise_ramp_duration(rise_d), .fall_ramp_duration(fall_d), .first_sink_level(lv1),
        .second_sink_level(lv2), .third_sink_level(lv3), .device_shutdown(dev_shdn)
    );
    rgbcfg_host_model i_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda_h));
    // Print counts and verdict, then end the run
    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Compare one value and count it
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Ramp length in ms for a field and a scaling code
    function automatic int ramp(input int f, input int sc);
        return (f == 0) ? 2 : (sc == 3) ? f * 16 : (f * 128) << sc;
    endfunction
    // Current in 0.125 mA steps, saturating
    function automatic int cur(input logic [7:0] c);
        return (c > 8'hBF) ? 192 : c + 1;
    endfunction
    // One index/data pair inside an open write
    task automatic pair(input logic [7:0] ix, input logic [7:0] v);
        i_host.byte_io(ix, rd, ack);
        chk("ack index", 1, ack);
        i_host.byte_io(v, rd, ack);
        chk("ack data", 1, ack);
        if (ix[3:0] inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8}) begin
            mdl[ix[3:0]] = v;
        end else if (ix[3:0] == 4'hA) begin
            mdl[10] = v & 8'h03;
        end
    endtask
    // Start and address a write
    task automatic wr_open();
        i_host.start_cond();
        i_host.byte_io(8'h60, rd, ack);
        chk("ack write address", 1, ack);
    endtask
    // Single-pair write
    task automatic wr1(input logic [3:0] ix, input logic [7:0] v);
        wr_open();
        pair({4'h5, ix}, v);
        i_host.stop_cond();
    endtask
    // Read one register back
    task automatic rd_chk(input logic [3:0] ix);
        i_host.start_cond();
        i_host.byte_io(8'h61, rd, ack);
        chk("ack read address", 1, ack);
        i_host.byte_io({4'hC, ix}, rd, ack);
        chk("ack read index", 1, ack);
        i_host.byte_io(8'hFF, rd, ack);
        chk("no ack after read data", 0, ack);
        i_host.stop_cond();
        chk("read data", mdl[ix], rd);
    endtask
    // Ramps, power state and four-phase sink sums
    task automatic out_chk();
        logic [15:0] s1 = 0, s2 = 0, s3 = 0;
        logic sh;
        sh = (mdl[10][1:0] == 2'h3);
        chk("rise", ramp(mdl[5][3:0], mdl[0][6:5]), rise_d);
        chk("fall", ramp(mdl[5][7:4], mdl[0][6:5]), fall_d);
        chk("shutdown", sh, dev_shdn);
        repeat (4) begin
            repeat (100) @(negedge mclk);
            s1 = s1 + lv1;
            s2 = s2 + lv2;
            s3 = s3 + lv3;
        end
        chk("sink1", sh ? 0 : cur(mdl[6]), s1);
        chk("sink2", sh ? 0 : cur(mdl[7]), s2);
        chk("sink3", sh ? 0 : cur(mdl[8]), s3);
    endtask
    // Main sequence
    initial begin
        foreach (mdl[i]) begin
            mdl[i] = 8'h00;
        end
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        repeat (5) @(posedge mclk);
        out_chk();
        rd_chk(4'h3);
        // Each scaling code, edge current codes, random values
        for (int n = 0; n < 6; n++) begin
            wr_open();
            for (int k = 0; k < 6; k++) begin
                d = 8'($random(seed));
                if (k == 0) begin
                    d = {1'b0, 2'(n), 5'h00};
                end else if (k > 1 && k < 5 && n < 4) begin
                    d = edge_codes[(n + k) % 4];
                end
                pair({4'(n + k), regs[k]}, d);
            end
            i_host.stop_cond();
            out_chk();
            foreach (regs[k]) begin
                rd_chk(regs[k]);
            end
        end
        // Foreign address is ignored
        i_host.start_cond();
        i_host.byte_io(8'h62, rd, ack);
        chk("ack foreign address", 0, ack);
        i_host.stop_cond();
        // Bus-line shutdown with SCL held low
        wr1(4'h0, 8'h08);
        wr1(4'hA, 8'h00);
        i_host.park();
        repeat (20) @(negedge mclk);
        chk("shutdown scl low", 1, dev_shdn);
        i_host.unpark();
        repeat (20) @(negedge mclk);
        chk("shutdown scl high", 0, dev_shdn);
        // SDA-low and both-low sub-modes; SCL parked low so no start is seen
        wr1(4'h0, 8'h10);
        i_host.park();
        repeat (20) @(negedge mclk);
        chk("shutdown sda high", 0, dev_shdn);
        i_host.sda_low();
        repeat (20) @(negedge mclk);
        chk("shutdown sda low", 1, dev_shdn);
        i_host.unpark();
        wr1(4'h0, 8'h18);
        i_host.park();
        repeat (20) @(negedge mclk);
        chk("shutdown scl only low", 0, dev_shdn);
        i_host.sda_low();
        repeat (20) @(negedge mclk);
        chk("shutdown both low", 1, dev_shdn);
        i_host.unpark();
        // Always on, then software sleep
        wr1(4'hA, 8'h01);
        i_host.park();
        repeat (20) @(negedge mclk);
        chk("always on", 0, dev_shdn);
        i_host.unpark();
        wr1(4'hA, 8'hFF);
        out_chk();
        rd_chk(4'hA);
        stop_test();
    end
    // Watchdog: a full run needs some 36k cycles
    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end
endmodule
`default_nettype wire
